// file: design/smb_pkg.sv
// shared constants for the message block framer
package smb_pkg;
    localparam logic [7:0]  SOH_BYTE       = 8'h01;
    localparam logic [7:0]  LINK_ID        = 8'h3f;
    localparam logic [7:0]  LINK_LEN       = 8'h08;
    localparam logic [7:0]  ACK_ID         = 8'h7e;
    localparam logic [7:0]  ACK_LEN        = 8'h05;
    localparam logic [7:0]  FILL_ID        = 8'h00;
    localparam int          ACK_SLOTS      = 5;
    localparam int          PWD_LEN        = 8;
    localparam int          CLK_HZ         = 25000000;
    localparam int          REPLY_MS       = 300;
    localparam int          CANCEL_MS      = 2000;
    localparam int          REPLY_CYC      = CLK_HZ / 1000 * REPLY_MS;
    localparam int          CANCEL_CYC     = CLK_HZ / 1000 * CANCEL_MS;
    localparam logic [63:0] DEV_PWD        = 64'h3030_302d_5350_4755;
    localparam logic [63:0] HOST_PWD       = 64'h3030_302d_5350_4755;
    typedef enum logic [2:0] {
        SMB_HUNT, SMB_ID, SMB_CMPL, SMB_LEN, SMB_DATA, SMB_CKL, SMB_CKH
    } smb_rx_state_t;
    typedef enum logic [1:0] {SMB_TX_IDLE, SMB_TX_BODY, SMB_TX_CKL, SMB_TX_CKH} smb_tx_state_t;
endpackage : smb_pkg

// file: design/smb_framer.sv
// message block deframer, acknowledge builder and link reply framer
`timescale 1ns/1ps
module smb_framer #(
    parameter int REPLY_CYC  = smb_pkg::REPLY_CYC,
    parameter int CANCEL_CYC = smb_pkg::CANCEL_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    input  wire logic [7:0] rx_byte,
    input  wire logic       rx_valid,
    input  wire logic       interval_tick,
    input  wire logic       tx_ready,
    output logic      [7:0] tx_byte,
    output logic            tx_valid,
    output logic            block_ok,
    output logic      [7:0] block_id,
    output logic            block_continuous,
    output logic            block_bad,
    output logic            cancel_requests
);
    if (REPLY_CYC < 1 || CANCEL_CYC < 1) begin : g_bad_timer
        $error("timer counts must be positive");
    end

    function automatic logic [15:0] cks_add(input logic [15:0] s, input logic [7:0] b);
        cks_add = s + {8'h00, b};
    endfunction : cks_add

    // receive side
    smb_pkg::smb_rx_state_t st_q, st_d;
    logic [7:0]  id_q, id_d;
    logic [7:0]  len_q, len_d;
    logic [7:0]  cnt_q, cnt_d;
    logic [7:0]  ckl_q, ckl_d;
    logic [15:0] sum_q, sum_d;
    logic [63:0] pwd_q, pwd_d;
    logic        ok_d, bad_d, link_hit;
    logic [7:0]  ack_q [smb_pkg::ACK_SLOTS];
    logic [7:0]  ack_d [smb_pkg::ACK_SLOTS];
    logic [2:0]  nack_q, nack_d;

    always_comb begin
        st_d = st_q;
        id_d = id_q;
        len_d = len_q;
        cnt_d = cnt_q;
        ckl_d = ckl_q;
        sum_d = sum_q;
        pwd_d = pwd_q;
        ok_d = 1'b0;
        bad_d = 1'b0;
        if (rx_valid) begin
            sum_d = cks_add(sum_q, rx_byte);
            unique case (st_q)
                smb_pkg::SMB_HUNT: begin
                    if (rx_byte == smb_pkg::SOH_BYTE) begin
                        st_d = smb_pkg::SMB_ID;
                        sum_d = {8'h00, rx_byte};
                    end
                end
                smb_pkg::SMB_ID: begin
                    id_d = rx_byte;
                    st_d = smb_pkg::SMB_CMPL;
                end
                smb_pkg::SMB_CMPL: begin
                    if (rx_byte == ~id_q) st_d = smb_pkg::SMB_LEN;
                    else if (id_q == smb_pkg::SOH_BYTE) begin
                        // id byte was a start byte; current byte is its id
                        id_d = rx_byte;
                        sum_d = cks_add({8'h00, smb_pkg::SOH_BYTE}, rx_byte);
                        st_d = smb_pkg::SMB_CMPL;
                    end else if (rx_byte == smb_pkg::SOH_BYTE) begin
                        sum_d = {8'h00, rx_byte};
                        st_d = smb_pkg::SMB_ID;
                    end else st_d = smb_pkg::SMB_HUNT;
                end
                smb_pkg::SMB_LEN: begin
                    len_d = rx_byte;
                    cnt_d = 8'h00;
                    st_d = (rx_byte == 8'h00) ? smb_pkg::SMB_CKL : smb_pkg::SMB_DATA;
                end
                smb_pkg::SMB_DATA: begin
                    if (cnt_q < 8'(smb_pkg::PWD_LEN))
                        pwd_d = {rx_byte, pwd_q[63:8]};
                    cnt_d = cnt_q + 8'h01;
                    if (cnt_q + 8'h01 == len_q) st_d = smb_pkg::SMB_CKL;
                end
                smb_pkg::SMB_CKL: begin
                    sum_d = sum_q;
                    ckl_d = rx_byte;
                    st_d = smb_pkg::SMB_CKH;
                end
                smb_pkg::SMB_CKH: begin
                    sum_d = sum_q;
                    ok_d = ({rx_byte, ckl_q} == sum_q);
                    bad_d = !ok_d;
                    st_d = smb_pkg::SMB_HUNT;
                end
                default: st_d = smb_pkg::SMB_HUNT;
            endcase
        end
    end

    assign link_hit = ok_d && id_q[6:0] == smb_pkg::LINK_ID[6:0]
                      && len_q == smb_pkg::LINK_LEN && pwd_q == smb_pkg::HOST_PWD;

    // transmit side
    smb_pkg::smb_tx_state_t tst_q, tst_d;
    logic [7:0]  txb_q, txb_d;
    logic [7:0]  tidx_q, tidx_d;
    logic        txv_q, txv_d;
    logic        ack_pend_q, ack_pend_d;
    logic        link_pend_q, link_pend_d;
    logic        is_link_q, is_link_d;
    logic [15:0] tsum_q, tsum_d;
    logic [7:0]  snap_q [smb_pkg::ACK_SLOTS];
    logic [7:0]  snap_d [smb_pkg::ACK_SLOTS];
    logic [31:0] rtmr_q, rtmr_d;
    logic [31:0] ctmr_q, ctmr_d;
    logic        cancel_q, cancel_d;

    function automatic logic [7:0] body_byte(input logic [7:0] i, input logic lk,
                                             input logic [7:0] s0, input logic [7:0] s1,
                                             input logic [7:0] s2, input logic [7:0] s3,
                                             input logic [7:0] s4);
        logic [7:0] b;
        b = 8'h00;
        unique case (i)
            8'd0: b = smb_pkg::SOH_BYTE;
            8'd1: b = lk ? smb_pkg::LINK_ID : smb_pkg::ACK_ID;
            8'd2: b = lk ? ~smb_pkg::LINK_ID : ~smb_pkg::ACK_ID;
            8'd3: b = lk ? smb_pkg::LINK_LEN : smb_pkg::ACK_LEN;
            8'd4: b = lk ? smb_pkg::DEV_PWD[7:0] : s0;
            8'd5: b = lk ? smb_pkg::DEV_PWD[15:8] : s1;
            8'd6: b = lk ? smb_pkg::DEV_PWD[23:16] : s2;
            8'd7: b = lk ? smb_pkg::DEV_PWD[31:24] : s3;
            8'd8: b = lk ? smb_pkg::DEV_PWD[39:32] : s4;
            8'd9: b = smb_pkg::DEV_PWD[47:40];
            8'd10: b = smb_pkg::DEV_PWD[55:48];
            8'd11: b = smb_pkg::DEV_PWD[63:56];
            default: b = 8'h00;
        endcase
        body_byte = b;
    endfunction : body_byte

    always_comb begin
        for (int i = 0; i < smb_pkg::ACK_SLOTS; i++) ack_d[i] = ack_q[i];
        for (int i = 0; i < smb_pkg::ACK_SLOTS; i++) snap_d[i] = snap_q[i];
        nack_d = nack_q;
        ack_pend_d = ack_pend_q;
        if (interval_tick && nack_q != 3'd0 && !ack_pend_q) begin
            for (int i = 0; i < smb_pkg::ACK_SLOTS; i++) snap_d[i] = ack_q[i];
            for (int i = 0; i < smb_pkg::ACK_SLOTS; i++) ack_d[i] = smb_pkg::FILL_ID;
            nack_d = 3'd0;
            ack_pend_d = 1'b1;
        end
        if (ok_d && rx_valid && nack_d < 3'(smb_pkg::ACK_SLOTS)) begin
            ack_d[nack_d] = id_q;
            nack_d = nack_d + 3'd1;
        end
        link_pend_d = link_pend_q || link_hit;
        rtmr_d = link_pend_q ? rtmr_q + 32'd1 : 32'd0;
        ctmr_d = ctmr_q;
        cancel_d = 1'b0;
        if (link_hit) ctmr_d = 32'(CANCEL_CYC);
        else if (ctmr_q != 32'd0) ctmr_d = ctmr_q - 32'd1;
        if (link_hit) cancel_d = 1'b1; // cancel at once, well inside 2 s
        tst_d = tst_q;
        txb_d = txb_q;
        txv_d = txv_q;
        tidx_d = tidx_q;
        tsum_d = tsum_q;
        is_link_d = is_link_q;
        if (txv_q && tx_ready) txv_d = 1'b0;
        if (!txv_q || tx_ready) begin
            unique case (tst_q)
                smb_pkg::SMB_TX_IDLE: begin
                    if (link_pend_q || ack_pend_q) begin // link reply first
                        is_link_d = link_pend_q;
                        tidx_d = 8'd0;
                        tsum_d = 16'h0000;
                        tst_d = smb_pkg::SMB_TX_BODY;
                    end
                end
                smb_pkg::SMB_TX_BODY: begin
                    txb_d = body_byte(tidx_q, is_link_q, snap_q[0], snap_q[1], snap_q[2],
                                      snap_q[3], snap_q[4]);
                    txv_d = 1'b1;
                    tsum_d = cks_add(tsum_q, txb_d);
                    tidx_d = tidx_q + 8'd1;
                    if (tidx_q == (is_link_q ? 8'd11 : 8'd8)) tst_d = smb_pkg::SMB_TX_CKL;
                end
                smb_pkg::SMB_TX_CKL: begin
                    txb_d = tsum_q[7:0];
                    txv_d = 1'b1;
                    tst_d = smb_pkg::SMB_TX_CKH;
                end
                smb_pkg::SMB_TX_CKH: begin
                    txb_d = tsum_q[15:8];
                    txv_d = 1'b1;
                    if (is_link_q) link_pend_d = link_hit;
                    else ack_pend_d = 1'b0;
                    tst_d = smb_pkg::SMB_TX_IDLE;
                end
                default: tst_d = smb_pkg::SMB_TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= smb_pkg::SMB_HUNT;
            id_q <= 8'h00;
            len_q <= 8'h00;
            cnt_q <= 8'h00;
            ckl_q <= 8'h00;
            sum_q <= 16'h0000;
            pwd_q <= 64'h0;
            nack_q <= 3'd0;
            for (int i = 0; i < smb_pkg::ACK_SLOTS; i++) ack_q[i] <= 8'h00;
            for (int i = 0; i < smb_pkg::ACK_SLOTS; i++) snap_q[i] <= 8'h00;
            tst_q <= smb_pkg::SMB_TX_IDLE;
            txb_q <= 8'h00;
            txv_q <= 1'b0;
            tidx_q <= 8'h00;
            tsum_q <= 16'h0000;
            is_link_q <= 1'b0;
            ack_pend_q <= 1'b0;
            link_pend_q <= 1'b0;
            rtmr_q <= 32'd0;
            ctmr_q <= 32'd0;
            cancel_q <= 1'b0;
            block_ok <= 1'b0;
            block_bad <= 1'b0;
            block_id <= 8'h00;
            block_continuous <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            id_q <= id_d;
            len_q <= len_d;
            cnt_q <= cnt_d;
            ckl_q <= ckl_d;
            sum_q <= sum_d;
            pwd_q <= pwd_d;
            nack_q <= nack_d;
            ack_q <= ack_d;
            snap_q <= snap_d;
            tst_q <= tst_d;
            txb_q <= txb_d;
            txv_q <= txv_d;
            tidx_q <= tidx_d;
            tsum_q <= tsum_d;
            is_link_q <= is_link_d;
            ack_pend_q <= ack_pend_d;
            link_pend_q <= link_pend_d;
            rtmr_q <= rtmr_d;
            ctmr_q <= ctmr_d;
            cancel_q <= cancel_d;
            block_ok <= ok_d && rx_valid;
            block_bad <= bad_d && rx_valid;
            if (ok_d && rx_valid) begin
                block_id <= id_q;
                block_continuous <= id_q[7];
            end
        end
    end

    assign tx_byte = txb_q;
    assign tx_valid = txv_q;
    assign cancel_requests = cancel_q;
endmodule : smb_framer

// file: dv/smb_framer_props.sv
// port assertions for the message block framer
`timescale 1ns/1ps
module smb_framer_props #(
    parameter int REPLY_CYC  = 100,
    parameter int CANCEL_CYC = 100
) (
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic       clk_en,
    input wire logic [7:0] rx_byte,
    input wire logic       rx_valid,
    input wire logic       interval_tick,
    input wire logic       tx_ready,
    input wire logic [7:0] tx_byte,
    input wire logic       tx_valid,
    input wire logic       block_ok,
    input wire logic [7:0] block_id,
    input wire logic       block_continuous,
    input wire logic       block_bad,
    input wire logic       cancel_requests
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("tx byte changed before accept");
    freeze_a: assert property (!clk_en |=> $stable(block_id) && $stable(tx_byte))
        else $error("state moved while clock enable low");
    ok_excl_a: assert property (block_ok |-> !block_bad)
        else $error("block both good and bad");
    ok_pulse_a: assert property (block_ok && clk_en |=> !block_ok)
        else $error("good pulse too long");
    bad_pulse_a: assert property (block_bad && clk_en |=> !block_bad)
        else $error("bad pulse too long");
    cont_bit_a: assert property (block_ok |-> block_continuous == block_id[7])
        else $error("continuous flag not id bit 7");
    cancel_id_a: assert property (cancel_requests |-> block_id[6:0] == 7'h3f)
        else $error("cancel without link init");
    cancel_pulse_a: assert property (cancel_requests && clk_en |=> !cancel_requests)
        else $error("cancel pulse too long");
    reply_soon_a: assert property (cancel_requests |-> ##[0:REPLY_CYC] tx_valid)
        else $error("link reply late");
endmodule : smb_framer_props

bind smb_framer smb_framer_props #(.REPLY_CYC(REPLY_CYC), .CANCEL_CYC(CANCEL_CYC)) u_props (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .interval_tick(interval_tick), .tx_ready(tx_ready),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .block_ok(block_ok), .block_id(block_id),
    .block_continuous(block_continuous), .block_bad(block_bad),
    .cancel_requests(cancel_requests));

// file: dv/smb_host_model.sv
// host side byte sink, prompt or stalling
`timescale 1ns/1ps
module smb_host_model (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       slow,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_valid,
    output logic            tx_ready
);
    logic [7:0] got[$];
    logic [2:0] cnt_q;
    // stalls seven of eight cycles when slow
    assign tx_ready = !slow || cnt_q == 3'h0;
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 3'h0;
        end else begin
            cnt_q <= cnt_q + 3'h1;
            if (tx_valid && tx_ready) got.push_back(tx_byte);
        end
    end
endmodule : smb_host_model

// file: dv/test_smb_framer.sv
// self-checking bench for the message block framer
`timescale 1ns/1ps
module test_smb_framer;
    logic       core_clk, rst_b, clk_en, rx_valid, interval_tick, slow, tx_ready, tx_valid;
    logic       block_ok, block_continuous, block_bad, cancel_requests;
    logic [7:0] rx_byte, tx_byte, block_id, id;
    logic [7:0] blk[$], acks[$], d[$];
    logic [31:0] seed;
    int         bad_count = 0, compares = 0, ok_n = 0, bad_n = 0, cn_n = 0, cyc = 0;

    smb_framer #(.REPLY_CYC(100), .CANCEL_CYC(100)) dut (.core_clk(core_clk), .rst_b(rst_b),
        .clk_en(clk_en), .rx_byte(rx_byte), .rx_valid(rx_valid), .interval_tick(interval_tick),
        .tx_ready(tx_ready), .tx_byte(tx_byte), .tx_valid(tx_valid), .block_ok(block_ok),
        .block_id(block_id), .block_continuous(block_continuous), .block_bad(block_bad),
        .cancel_requests(cancel_requests));
    smb_host_model host (.core_clk(core_clk), .rst_b(rst_b), .slow(slow), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .tx_ready(tx_ready));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc++;
        ok_n += int'(block_ok);
        bad_n += int'(block_bad);
        cn_n += int'(cancel_requests);
        if (cyc > 20000) begin
            bad_count++;
            finish_test();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [15:0] csum(logic [7:0] q[$]);
        logic [15:0] s = 16'h0000;
        foreach (q[i]) s += {8'h00, q[i]};
        return s;
    endfunction : csum

    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask : check

    task automatic put(input logic [7:0] b);
        if (rnd() % 4 == 0 && !tx_valid) begin
            clk_en = 1'b0;
            @(negedge core_clk);
            clk_en = 1'b1;
        end
        rx_byte = b;
        rx_valid = 1'b1;
        @(negedge core_clk);
    endtask : put

    task automatic send(input logic [7:0] i, input logic [7:0] n, input logic good);
        int o;
        int b;
        logic [15:0] s;
        o = ok_n;
        b = bad_n;
        blk = {8'h01, i, ~i, n};
        for (int k = 0; k < n; k++) blk.push_back(i == 8'h3f ? smb_pkg::HOST_PWD[8*k+:8] : 8'(rnd()));
        s = csum(blk) ^ {15'h0000, !good};
        blk = {blk, s[7:0], s[15:8]};
        foreach (blk[k]) put(blk[k]);
        rx_valid = 1'b0;
        repeat (3) @(negedge core_clk);
        check(ok_n === o + int'(good) && bad_n === b + int'(!good), "block verdict");
        if (good) check(block_id === i, "block id");
        if (good && acks.size() < 5) acks.push_back(i);
    endtask : send

    task automatic expect_out(input logic [7:0] i, input logic [7:0] q[$]);
        logic [7:0] e[$];
        logic [15:0] s;
        e = {8'h01, i, ~i, 8'(q.size()), q};
        s = csum(e);
        e = {e, s[7:0], s[15:8]};
        for (int k = 0; k < 3000 && host.got.size() < e.size(); k++) @(negedge core_clk);
        check(host.got.size() === e.size(), "frame length");
        foreach (e[k]) check(host.got[k] === e[k], "frame byte");
        host.got.delete();
    endtask : expect_out

    task automatic finish_test();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    initial begin
        seed = 32'h0000ea1c;
        {rst_b, rx_valid, interval_tick, slow, rx_byte} = 12'h000;
        clk_en = 1'b1;
        repeat (12) @(negedge core_clk);
        rst_b = 1'b1;
        foreach (blk[k]) put(8'h00);
        put(8'h55);
        put(8'hfe);
        send(8'h3f, 8'h08, 1'b1);
        check(cn_n === 1, "cancel pulse");
        for (int k = 0; k < 8; k++) d.push_back(smb_pkg::DEV_PWD[8*k+:8]);
        expect_out(8'h3f, d);
        $display("test link done");
        slow = 1'b1;
        for (int k = 0; k < 7; k++) begin
            id = (8'(rnd()) & 8'h9e) | 8'h40;
            if (k == 2) put(8'h01);
            send(id, 8'(rnd() % 8), k % 3 != 1);
        end
        while (acks.size() < 5) acks.push_back(8'h00);
        interval_tick = 1'b1;
        @(negedge core_clk);
        interval_tick = 1'b0;
        expect_out(8'h7e, acks);
        interval_tick = 1'b1;
        @(negedge core_clk);
        interval_tick = 1'b0;
        repeat (60) @(negedge core_clk);
        check(host.got.size() === 0, "no empty ack");
        $display("test ack done");
        finish_test();
    end
endmodule : test_smb_framer
